// file: src/lemc_defines.svh
`ifndef LEMC_DEFINES_SVH
`define LEMC_DEFINES_SVH

// clock rate in kHz
`define LEMC_CLK_KHZ        25000
// program pulse width in microseconds
`define LEMC_PULSE_US       100
// pulse cycles: 100 us at 25 MHz
`define LEMC_PULSE_CYC      ((`LEMC_PULSE_US * `LEMC_CLK_KHZ) / 1000)
// setup/hold time in microseconds (address, data, supply)
`define LEMC_SETUP_US       2
`define LEMC_SETUP_CYC      (((`LEMC_SETUP_US * `LEMC_CLK_KHZ) + 999) / 1000)
// output-enable to data valid in program verify, ns
`define LEMC_GATE_NS        150
`define LEMC_GATE_CYC       (((`LEMC_GATE_NS * `LEMC_CLK_KHZ) + 999999) / 1000000)
// output float after output enable rises, ns
`define LEMC_FLOAT_NS       130
`define LEMC_FLOAT_CYC      (((`LEMC_FLOAT_NS * `LEMC_CLK_KHZ) + 999999) / 1000000)
// synchroniser delay on the data pins, cycles
`define LEMC_SYNC_CYC       2
// pulse budget per byte
`define LEMC_MAX_PULSES     25
// erased byte value
`define LEMC_ERASED         8'hff
// identifier address: bit zero selects maker or part code
`define LEMC_ID_MAKER_ADDR  15'h0000
`define LEMC_ID_PART_ADDR   15'h0001

`endif

// file: src/lemc_pkg.sv
package lemc_pkg;

	typedef enum logic [1:0]
	{
		LEMC_CMD_PROGRAM,
		LEMC_CMD_ID,
		LEMC_CMD_BLANK
	} lemc_cmd_t;

endpackage

// file: src/lemc_timer.sv
`timescale 1ns/100ps
`include "lemc_defines.svh"

module lemc_timer
#(
	parameter int W = 12
)
(
	// clock and reset
	input  wire logic         clock,
	input  wire logic         resetn,
	// control
	input  wire logic         load,
	input  wire logic [W-1:0] count,
	output logic              done
);

	logic [W-1:0] cnt_r;

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			cnt_r <= '0;
		else if (load)
			cnt_r <= count;
		else if (cnt_r != '0)
			cnt_r <= cnt_r - 1'b1;
	end

	// done must not look at load, or load and done would chase each other
	assign done = (cnt_r == '0);

endmodule

// file: src/lemc_programmer.sv
`timescale 1ns/100ps
`include "lemc_defines.svh"

module lemc_programmer
	import lemc_pkg::*;
#(
	parameter int AW         = 15,
	parameter int MAX_PULSES = `LEMC_MAX_PULSES
)
(
	// clock and reset
	input  wire logic          clock,
	input  wire logic          resetn,
	// command port
	input  wire logic          start,
	input  wire lemc_cmd_t     cmd,
	input  wire logic [AW-1:0] first_addr,
	input  wire logic [AW-1:0] last_addr,
	output logic               busy,
	output logic               done,
	output logic               failed,
	output logic [AW-1:0]      fail_addr,
	output logic [7:0]         maker_code,
	output logic [7:0]         part_code,
	// write data source
	output logic               wdata_req,
	output logic [AW-1:0]      wdata_addr,
	input  wire logic [7:0]    wdata,
	// device pins
	output logic [AW-1:0]      mem_addr,
	output logic               chip_sel_n,
	output logic               out_en_n,
	output logic               latch_strobe,
	output logic               prog_supply_on,
	output logic               prog_vcc_on,
	output logic               id_voltage_on,
	input  wire logic [7:0]    data_in,
	output logic [7:0]         data_out,
	output logic               data_oe
);

	////////////////////////////////////////////////////////////////////////////////
	typedef enum logic [3:0]
	{
		ST_IDLE, ST_SUPPLY, ST_LOAD, ST_SETUP, ST_PULSE, ST_HOLD,
		ST_VERIFY, ST_FLOAT, ST_NEXT, ST_ID, ST_END
	} lemc_state_t;

	localparam int TW = 12;

	lemc_state_t     state_r;
	logic [AW-1:0]   addr_r;
	logic [7:0]      wbyte_r;
	logic [7:0]      din_s1_r;
	logic [7:0]      din_s2_r;
	logic [7:0]      rbyte_r;
	logic [5:0]      pulses_r;
	logic            id_part_r;
	logic            blank_r;
	logic            load;
	logic [TW-1:0]   load_cnt;
	logic            t_done;

	// expected read-back: only zeros get programmed, so blank check wants all ones
	function automatic logic [7:0] expect_byte(input logic blank, input logic [7:0] w);
		expect_byte = blank ? `LEMC_ERASED : w;
	endfunction

	lemc_timer #(.W(TW)) u_timer
	(
		.clock  (clock),
		.resetn (resetn),
		.load   (load),
		.count  (load_cnt),
		.done   (t_done)
	);

	////////////////////////////////////////////////////////////////////////////////
	// data pins are asynchronous to us: two flops before any use
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			din_s1_r <= 8'h00;
			din_s2_r <= 8'h00;
		end
		else
		begin
			din_s1_r <= data_in;
			din_s2_r <= din_s1_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// timer loads on start and on leaving each timed state, except SETUP in blank check
	always_comb
	begin
		load = 1'b0;
		load_cnt = '0;
		if (state_r == ST_SUPPLY && t_done)
		begin
			load = 1'b1;
			load_cnt = TW'(`LEMC_SETUP_CYC);
		end
		else if (state_r == ST_SETUP && t_done)
		begin
			load = !blank_r;
			load_cnt = TW'(`LEMC_PULSE_CYC);
		end
		else if ((state_r == ST_PULSE || state_r == ST_NEXT) && t_done)
		begin
			load = 1'b1;
			load_cnt = TW'(`LEMC_SETUP_CYC);
		end
		else if (state_r == ST_HOLD && t_done)
		begin
			load = 1'b1;
			load_cnt = TW'(`LEMC_GATE_CYC + `LEMC_SYNC_CYC);
		end
		else if (state_r == ST_VERIFY && t_done)
		begin
			load = 1'b1;
			load_cnt = TW'(`LEMC_FLOAT_CYC);
		end
		else if (state_r == ST_FLOAT && t_done)
		begin
			// a retry pulse needs its data setup again
			load = 1'b1;
			load_cnt = TW'(`LEMC_SETUP_CYC);
		end
		else if (state_r == ST_ID && t_done)
		begin
			load = 1'b1;
			load_cnt = TW'(`LEMC_GATE_CYC + `LEMC_SYNC_CYC);
		end
		else if (state_r == ST_IDLE && start)
		begin
			load = 1'b1;
			load_cnt = TW'(`LEMC_SETUP_CYC);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// sequencer
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			state_r   <= ST_IDLE;
			addr_r    <= '0;
			wbyte_r   <= 8'h00;
			rbyte_r   <= 8'h00;
			pulses_r  <= '0;
			id_part_r <= 1'b0;
			blank_r   <= 1'b0;
			failed    <= 1'b0;
			fail_addr <= '0;
			done      <= 1'b0;
			maker_code <= 8'h00;
			part_code <= 8'h00;
		end
		else
		begin
			done <= 1'b0;
			case (state_r)
				ST_IDLE:
					if (start)
					begin
						addr_r    <= (cmd == LEMC_CMD_ID) ? `LEMC_ID_MAKER_ADDR : first_addr;
						id_part_r <= 1'b0;
						blank_r   <= (cmd == LEMC_CMD_BLANK);
						failed    <= 1'b0;
						state_r   <= (cmd == LEMC_CMD_ID) ? ST_ID : ST_SUPPLY;
					end
				ST_SUPPLY:
					if (t_done)
						state_r <= ST_LOAD;
				ST_LOAD:
				begin
					wbyte_r  <= wdata;
					pulses_r <= '0;
					state_r  <= ST_SETUP;
				end
				ST_SETUP:
					if (t_done)
						state_r <= blank_r ? ST_HOLD : ST_PULSE;
				ST_PULSE:
					if (t_done)
					begin
						pulses_r <= pulses_r + 6'd1;
						state_r  <= ST_HOLD;
					end
				ST_HOLD:
					if (t_done)
						state_r <= ST_VERIFY;
				ST_VERIFY:
					if (t_done)
					begin
						// take the byte while it is driven; the pins float in FLOAT
						rbyte_r <= din_s2_r;
						state_r <= ST_FLOAT;
					end
				ST_FLOAT:
					if (t_done)
					begin
						if (rbyte_r == expect_byte(blank_r, wbyte_r))
							state_r <= ST_NEXT;
						else if (blank_r || pulses_r >= 6'(MAX_PULSES))
						begin
							failed    <= 1'b1;
							fail_addr <= addr_r;
							state_r   <= ST_END;
						end
						else
							state_r <= ST_SETUP;
					end
				ST_NEXT:
					if (addr_r == last_addr)
						state_r <= ST_END;
					else
					begin
						addr_r  <= addr_r + 1'b1;
						state_r <= ST_LOAD;
					end
				ST_ID:
					if (t_done)
					begin
						// address pins act directly, no strobe needed
						if (id_part_r)
						begin
							part_code <= din_s2_r;
							state_r   <= ST_END;
						end
						else
						begin
							maker_code <= din_s2_r;
							id_part_r  <= 1'b1;
							addr_r     <= `LEMC_ID_PART_ADDR;
						end
					end
				ST_END:
				begin
					done    <= 1'b1;
					state_r <= ST_IDLE;
				end
				default:
					state_r <= ST_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// pin drive
	logic supplies;
	assign supplies = (state_r inside {ST_SUPPLY, ST_LOAD, ST_SETUP, ST_PULSE, ST_HOLD,
		ST_VERIFY, ST_FLOAT, ST_NEXT});

	assign busy           = (state_r != ST_IDLE);
	assign wdata_req      = (state_r == ST_LOAD);
	assign wdata_addr     = addr_r;
	assign mem_addr       = addr_r;
	// raised supply bypasses the latch; strobe kept high (transparent) anyway
	assign latch_strobe   = 1'b1;
	assign prog_supply_on = supplies;
	assign prog_vcc_on    = supplies;
	assign id_voltage_on  = (state_r == ST_ID);
	// select pulses low for the program pulse and is held low in ID; high elsewhere inhibits
	assign chip_sel_n     = !((state_r == ST_PULSE) || (state_r == ST_ID));
	// enable alone gates the read; select stays high in verify
	assign out_en_n       = !((state_r == ST_VERIFY) || (state_r == ST_ID));
	assign data_out       = wbyte_r;
	assign data_oe        = (state_r == ST_SETUP) || (state_r == ST_PULSE)
		|| (state_r == ST_HOLD);

endmodule

// file: testbench/lemc_chk.sv
`timescale 1ns/100ps
module lemc_chk
#(
	parameter int AW         = 15,
	parameter int MAX_PULSES = 25
)
(
	input wire logic          clock,
	input wire logic          resetn,
	input wire logic          busy,
	input wire logic          done,
	input wire logic [AW-1:0] mem_addr,
	input wire logic          chip_sel_n,
	input wire logic          out_en_n,
	input wire logic          prog_supply_on,
	input wire logic          prog_vcc_on,
	input wire logic          id_voltage_on,
	input wire logic [7:0]    data_out,
	input wire logic          data_oe
);
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	logic [11:0]   low_r;
	logic [5:0]    pulses_r;
	logic [AW-1:0] addr_r;
	////////////////////////////////////////////////////////////////
	// pulse length and pulses spent on the current byte
	always_ff @(posedge clock or negedge resetn)
		if (!resetn)
		begin
			low_r    <= 12'h000;
			pulses_r <= 6'h00;
			addr_r   <= '0;
		end
		else
		begin
			low_r  <= (!chip_sel_n && out_en_n) ? low_r + 12'h001 : 12'h000;
			addr_r <= mem_addr;
			if (!busy || mem_addr != addr_r)
				pulses_r <= 6'h00;
			else if (low_r == 12'h001)
				pulses_r <= pulses_r + 6'h01;
		end
	sequence pulse_end_s;
		$rose(chip_sel_n) ##0 prog_supply_on;
	endsequence
	////////////////////////////////////////////////////////////////
	idle_pins_a: assert property (!busy [*2] |-> chip_sel_n && out_en_n && !data_oe)
		else $error("pins active while idle");
	bus_free_a: assert property (data_oe |-> out_en_n)
		else $error("data driven against device output");
	pulse_supply_a: assert property (!chip_sel_n && out_en_n |-> prog_supply_on && data_oe)
		else $error("select pulse without supply or data");
	vcc_first_a: assert property (prog_supply_on |-> prog_vcc_on)
		else $error("program supply without raised core supply");
	pulse_width_a: assert property (pulse_end_s |-> low_r >= 12'h947 && low_r <= 12'ha41)
		else $error("program pulse width wrong");
	data_steady_a: assert property (!chip_sel_n && out_en_n && !$past(chip_sel_n) |->
		$stable(data_out) && $stable(mem_addr))
		else $error("data or address moved in pulse");
	verify_select_a: assert property (!out_en_n && prog_supply_on |-> chip_sel_n)
		else $error("verify with select low");
	pulse_budget_a: assert property (pulses_r <= MAX_PULSES)
		else $error("pulse budget exceeded");
	id_address_a: assert property (id_voltage_on && !out_en_n |->
		!chip_sel_n && mem_addr[8:1] == 8'h00 && mem_addr[12:10] == 3'h0)
		else $error("identifier read setup wrong");
	done_pulse_a: assert property (done |=> !done)
		else $error("done longer than one cycle");
endmodule
bind lemc_programmer lemc_chk #(.AW(AW), .MAX_PULSES(MAX_PULSES)) lemc_chk_inst (.*);

// file: testbench/lemc_dev_model.sv
`timescale 1ns/100ps
module lemc_dev_model
#(
	parameter logic [7:0] MAKER = 8'h5a, // arbitrary value
	parameter logic [7:0] PART  = 8'h3c  // arbitrary value
)
(
	input wire logic [14:0] mem_addr,
	input wire logic        chip_sel_n,
	input wire logic        out_en_n,
	input wire logic        latch_strobe,
	input wire logic        prog_supply_on,
	input wire logic        id_voltage_on,
	input wire logic [7:0]  data_out,
	input wire logic        data_oe,
	input wire logic [14:0] stuck_addr,
	output logic [7:0]      data_in
);
	logic [7:0]  mem [0:32767];
	logic [14:0] la;
	logic [7:0]  last;
	logic        drv;
	initial
	begin
		foreach (mem[i])
			mem[i] = 8'hff;
		last = 8'h00;
	end
	always @*
		if (latch_strobe || prog_supply_on || id_voltage_on)
			la = mem_addr;
	// stuck cell keeps bit zero set, so it never verifies
	always @(posedge chip_sel_n)
		if (prog_supply_on && out_en_n && data_oe)
			mem[la] = mem[la] & (la == stuck_addr ? data_out | 8'h01 : data_out);
	assign drv = !out_en_n && (!chip_sel_n || prog_supply_on);
	always @*
		if (data_oe)
			data_in = data_out;
		else if (drv)
			data_in = id_voltage_on ? (la[0] ? PART : MAKER) : mem[la];
		else
			data_in = ~last; // a floating bus must not look like held data
	always @(data_in)
		if (drv)
			last = data_in;
endmodule

// file: testbench/tb_lemc_programmer.sv
`timescale 1ns/100ps
module tb_lemc_programmer;
	import lemc_pkg::*;
	localparam int NP = 3;
	logic        clock, resetn, start, busy, done, failed, wdata_req, data_oe, latch_strobe;
	logic        chip_sel_n, out_en_n, prog_supply_on, prog_vcc_on, id_voltage_on;
	lemc_cmd_t   cmd;
	logic [14:0] first_addr, last_addr, fail_addr, wdata_addr, mem_addr, stuck, base;
	logic [7:0]  maker_code, part_code, wdata, data_in, data_out, key;
	int          n_fail, num_checks, pulses, loads;
	lemc_programmer #(.AW(15), .MAX_PULSES(NP)) lemc_programmer_inst (.*);
	lemc_dev_model lemc_dev_model_inst (.*, .stuck_addr(stuck));
	// bit zero always cleared so every written byte differs from erased
	assign wdata = (wdata_addr[7:0] ^ key) & 8'hfe;
	function automatic logic [7:0] pat(input logic [14:0] a);
		return (a[7:0] ^ key) & 8'hfe;
	endfunction
	always @(posedge chip_sel_n)
		if (prog_supply_on)
			pulses++;
	// each byte must be fetched once, retries reuse it
	always @(posedge clock)
		if (wdata_req)
			loads++;
	////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// a second start while busy must be ignored
	task automatic run(input lemc_cmd_t c, input logic [14:0] f, input logic [14:0] l);
		int n;
		@(posedge clock);
		cmd        <= c;
		first_addr <= f;
		last_addr  <= l;
		start      <= 1'b1;
		pulses = 0;
		loads = 0;
		n = 0;
		while (done !== 1'b1 && n < 40000)
		begin
			@(posedge clock);
			start <= (n == 10);
			cmd   <= (n == 10) ? LEMC_CMD_BLANK : c;
			n++;
		end
		check("done", done, 1'b1);
		check("busy", busy, 1'b0);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial
	begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	initial
	begin
		repeat (60000) @(posedge clock);
		n_fail++;
		tally_and_finish();
	end
	initial
	begin
		resetn = 1'b0;
		start = 1'b0;
		cmd = LEMC_CMD_BLANK;
		first_addr = 15'h0000;
		last_addr = 15'h0000;
		stuck = 15'h7fff;
		n_fail = 0;
		num_checks = 0;
		void'($urandom(32'h98b4));
		key = 8'($urandom);
		base = 15'($urandom_range(0, 32000));
		repeat (20) @(posedge clock);
		resetn <= 1'b1;
		run(LEMC_CMD_BLANK, base, base + 15'h0003);
		check("blank failed", failed, 1'b0);
		$display("test blank done");
		run(LEMC_CMD_PROGRAM, base, base + 15'h0002);
		check("program failed", failed, 1'b0);
		check("pulses", pulses[15:0], 16'h0003);
		check("loads", loads[15:0], 16'h0003);
		for (int i = 0; i < 4; i++)
			check("cell", lemc_dev_model_inst.mem[base + i], i < 3 ? pat(base + i) : 8'hff);
		$display("test program done");
		run(LEMC_CMD_BLANK, base, base + 15'h0003);
		check("blank trip", failed, 1'b1);
		check("blank addr", fail_addr, base);
		$display("test blank trip done");
		stuck = base + 15'h0004;
		run(LEMC_CMD_PROGRAM, stuck, stuck);
		check("stuck failed", failed, 1'b1);
		check("stuck addr", fail_addr, stuck);
		check("stuck pulses", pulses[15:0], NP[15:0]);
		check("stuck loads", loads[15:0], 16'h0001);
		$display("test stuck done");
		run(LEMC_CMD_ID, 15'h0000, 15'h0000);
		check("maker", maker_code, 8'h5a);
		check("part", part_code, 8'h3c);
		check("flag cleared", failed, 1'b0);
		$display("test identifier done");
		tally_and_finish();
	end
endmodule
